// File: common/pwrmgr_pkg.sv
// constants for the power clock manager block
package pwrmgr_pkg;
  localparam logic [7:0] ADDR_PCER = 8'h10;
  localparam logic [7:0] ADDR_PCDR = 8'h14;
  localparam logic [7:0] ADDR_PCSR = 8'h18;
  localparam logic [7:0] ADDR_CGMR = 8'h20;
  localparam logic [7:0] ADDR_PCR  = 8'h28;
  localparam logic [7:0] ADDR_PMR  = 8'h2c;
  localparam logic [7:0] ADDR_SR   = 8'h30;
  localparam logic [7:0] ADDR_IER  = 8'h34;
  localparam logic [7:0] ADDR_IDR  = 8'h38;
  localparam logic [7:0] ADDR_IMR  = 8'h3c;

  localparam logic [31:0] PCSR_IMPL  = 32'h0007_effc;
  localparam logic [31:0] CGMR_RESET = 32'h0000_0000;
  localparam logic [7:0]  PMR_RESET  = 8'h01;
  localparam logic [31:0] CGMR_MASK  = 32'h3fff_ff77;

  localparam int BYP_BIT = 0;
  localparam int OSCEN_BIT = 1;
  localparam int CKODS_BIT = 2;
  localparam int PRESCALE_LSB = 4;
  localparam int FACTOR_LSB = 8;
  localparam int SOURCE_LSB = 14;
  localparam int OSCNT_LSB = 16;
  localparam int PLLCNT_LSB = 24;
  // power pin setup and power command fields
  localparam int ALWAKE_BIT = 4;
  localparam int ALOFF_BIT = 5;
  localparam int EDGE_LSB = 6;
  localparam int OFF_BIT = 0;
  localparam int ACK_BIT = 1;

  // slow clock tick periods in system clock cycles at 100 MHz
  localparam int CLK_HZ = 100_000_000;
  localparam int SLOW_HZ = 32_768;
  localparam int OSC_DIV = 8;
  localparam int SLOW_CYC = CLK_HZ / SLOW_HZ;
  localparam int OSC_CYC = CLK_HZ / (SLOW_HZ / OSC_DIV);

  localparam logic [1:0] LVL_TRIS = 2'b00;
  localparam logic [1:0] LVL_LOW  = 2'b01;
  localparam logic [1:0] LVL_HIGH = 2'b10;
  localparam logic [1:0] EDGE_POS = 2'b01;
  localparam logic [1:0] EDGE_NEG = 2'b10;
  localparam logic [1:0] EDGE_BOTH = 2'b11;
  localparam logic [1:0] SRC_SLOW = 2'b00;
  localparam logic [1:0] SRC_MAIN = 2'b01;
  localparam logic [1:0] SRC_PLL  = 2'b10;
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;

  typedef enum logic [0:0] {
    PWRMGR_WAKE = 1'b0,
    PWRMGR_OFF  = 1'b1
  } pwrmgr_pin_state_t;
endpackage : pwrmgr_pkg

// File: rtl/pwrmgr_top.sv
// power clock manager: registers, timers, shut-down pin logic
//
// Contract
// [R1] clock status bit reads peripheral running
// [R2] bypass bit selects external crystal-input clock
// [R3] software never sets enable with bypass
// [R4] clock output driven unless disable bit
// [R5] prescaler codes divide by power of two
// [R6] factor zero stops pll, else times plus one
// [R7] source code picks slow, main, pll
// [R8] oscillator timer preloads on enable, nonzero
// [R9] lock timer preloads on factor write
// [R10] software programs lock count two or more
// [R11] shutdown command drives shutdown level
// [R12] wake ack command drives wake level
// [R13] wake ack wins over shutdown
// [R14] shutdown level: tri, low, high
// [R15] wake level: tri, low, high
// [R16] alarm wakes when alarm wake enabled
// [R17] alarm shuts down only when wake disabled
// [R18] wake edge field picks detected edges
// [R19] stable flag set when timer reaches zero
// [R20] lock flag set when lock timer zero
// [R21] enable register sets mask bits
// [R22] disable register clears mask bits
// [R23] mask register reads enabled interrupts
// [R24] clock enable and disable registers
// [R25] reset starts in wake state, tri pin
// [R26] interrupt when flag and mask both set
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
module pwrmgr_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        wake_input_pin,
  input  wire logic        rtc_alarm,
  output logic             power_off_pin_o,
  output logic             power_off_pin_oe_n,
  output logic             clk_out_pin_oe_n,
  output logic             osc_bypass,
  output logic             osc_enable,
  output logic [1:0]       source_sel,
  output logic [2:0]       prescale_sel,
  output logic [5:0]       pll_factor,
  output logic             pll_on,
  output logic [31:0]      periph_clk_on,
  output logic             irq
);
  // write address/data latches
  logic        aw_full, next_aw_full, w_full, next_w_full;
  logic [7:0]  aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic        bvalid, next_bvalid, rvalid, next_rvalid;
  logic [31:0] rdata, next_rdata;
  logic [1:0]  bresp, next_bresp, rresp, next_rresp;
  logic        wr_go, aw_rdy, w_rdy, ar_rdy;
  logic [31:0] pcsr, next_pcsr, cgmr, next_cgmr;
  logic [7:0]  pmr, next_pmr;
  logic [1:0]  imr, next_imr;
  pwrmgr_pkg::pwrmgr_pin_state_t pin_st, next_pin_st;
  logic        pin_o, next_pin_o, pin_oe_n, next_pin_oe_n;
  logic        ckoe_n, next_ckoe_n, irq_q, next_irq;
  logic [7:0]  osc_cnt, next_osc_cnt;
  logic [7:0]  pll_cnt, next_pll_cnt;
  logic        osc_run, next_osc_run, pll_run, next_pll_run;
  logic        stable, next_stable, locked, next_locked;
  logic [15:0] slow_div, next_slow_div;
  logic [15:0] osc_div, next_osc_div;
  logic        wk_s1, wk_s2, wk_d, al_s1, al_s2, al_d;

  function automatic logic tick(input logic [15:0] cnt, input int period);
    tick = (cnt == 16'(period - 1));
  endfunction : tick
  function automatic logic [1:0] strb_ok(input logic [7:0] a);
    strb_ok = (a == pwrmgr_pkg::ADDR_PCER || a == pwrmgr_pkg::ADDR_PCDR ||
               a == pwrmgr_pkg::ADDR_CGMR || a == pwrmgr_pkg::ADDR_PCR ||
               a == pwrmgr_pkg::ADDR_PMR || a == pwrmgr_pkg::ADDR_IER ||
               a == pwrmgr_pkg::ADDR_IDR) ? pwrmgr_pkg::RESP_OK
                                          : pwrmgr_pkg::RESP_ERR;
  endfunction : strb_ok
  // pin inputs pass two flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {wk_s1, wk_s2, wk_d, al_s1, al_s2, al_d} <= '0;
    end else begin
      wk_s1 <= wake_input_pin;
      wk_s2 <= wk_s1;
      wk_d  <= wk_s2;
      al_s1 <= rtc_alarm;
      al_s2 <= al_s1;
      al_d  <= al_s2;
    end
  end

  logic wk_rise, wk_fall, wake_edge, alarm_ev;
  always_comb begin
    wk_rise = wk_s2 & ~wk_d;
    wk_fall = ~wk_s2 & wk_d;
    alarm_ev = al_s2 & ~al_d;
    case (pmr[pwrmgr_pkg::EDGE_LSB +: 2])
      pwrmgr_pkg::EDGE_POS:  wake_edge = wk_rise; // R18
      pwrmgr_pkg::EDGE_NEG:  wake_edge = wk_fall; // R18
      pwrmgr_pkg::EDGE_BOTH: wake_edge = wk_rise | wk_fall; // R18
      default:               wake_edge = 1'b0;
    endcase
  end
  assign wr_go = aw_full & w_full & ~bvalid;
  // bus slave: writes take address and data in either order
  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full  = w_full;
    next_w_data  = w_data;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (s_axi_awvalid && !aw_full) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_full) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
    end
    if (wr_go) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = strb_ok(aw_addr);
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end else if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp  = pwrmgr_pkg::RESP_OK;
      case (s_axi_araddr)
        pwrmgr_pkg::ADDR_PCSR: next_rdata = pcsr; // R1
        pwrmgr_pkg::ADDR_CGMR: next_rdata = cgmr;
        pwrmgr_pkg::ADDR_PMR:  next_rdata = {24'h00_0000, pmr};
        pwrmgr_pkg::ADDR_SR:   next_rdata = {30'h0, locked, stable};
        pwrmgr_pkg::ADDR_IMR:  next_rdata = {30'h0, imr}; // R23
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = pwrmgr_pkg::RESP_ERR;
        end
      endcase
    end
  end
  // register writes and their side effects
  logic [31:0] wd;
  logic        factor_wr, osc_set;
  always_comb begin
    wd = w_data;
    next_pcsr = pcsr;
    next_cgmr = cgmr;
    next_pmr  = pmr;
    next_imr  = imr;
    next_pin_st = pin_st;
    factor_wr = 1'b0;
    osc_set   = 1'b0;
    if (wr_go && s_axi_wstrb == 4'hf) begin
      case (aw_addr)
        pwrmgr_pkg::ADDR_PCER:
          next_pcsr = pcsr | (wd & pwrmgr_pkg::PCSR_IMPL); // R24
        pwrmgr_pkg::ADDR_PCDR:
          next_pcsr = pcsr & ~(wd & pwrmgr_pkg::PCSR_IMPL); // R24
        pwrmgr_pkg::ADDR_CGMR: begin
          next_cgmr = wd & pwrmgr_pkg::CGMR_MASK;
          factor_wr = 1'b1;
          osc_set = wd[pwrmgr_pkg::OSCEN_BIT] & ~cgmr[pwrmgr_pkg::OSCEN_BIT];
        end
        pwrmgr_pkg::ADDR_PMR: next_pmr = wd[7:0];
        pwrmgr_pkg::ADDR_PCR: begin // R11 R12 R13
          if (wd[pwrmgr_pkg::OFF_BIT]) next_pin_st = pwrmgr_pkg::PWRMGR_OFF;
          if (wd[pwrmgr_pkg::ACK_BIT]) next_pin_st = pwrmgr_pkg::PWRMGR_WAKE;
        end
        pwrmgr_pkg::ADDR_IER: next_imr = imr | wd[1:0]; // R21
        pwrmgr_pkg::ADDR_IDR: next_imr = imr & ~wd[1:0]; // R22
        default: ;
      endcase
    end
    if (wake_edge || (alarm_ev && pmr[pwrmgr_pkg::ALWAKE_BIT])) begin
      next_pin_st = pwrmgr_pkg::PWRMGR_WAKE; // R16
    end else if (alarm_ev && pmr[pwrmgr_pkg::ALOFF_BIT]) begin
      next_pin_st = pwrmgr_pkg::PWRMGR_OFF; // R17
    end
  end

  // pin level from state and selection fields
  logic [1:0] lvl;
  always_comb begin
    lvl = (next_pin_st == pwrmgr_pkg::PWRMGR_OFF) ? next_pmr[1:0]
                                                  : next_pmr[3:2]; // R14 R15
    next_pin_oe_n = 1'b1;
    next_pin_o = 1'b0;
    case (lvl)
      pwrmgr_pkg::LVL_LOW: next_pin_oe_n = 1'b0;
      pwrmgr_pkg::LVL_HIGH: begin
        next_pin_oe_n = 1'b0;
        next_pin_o = 1'b1;
      end
      default: ;
    endcase
    next_ckoe_n = next_cgmr[pwrmgr_pkg::CKODS_BIT]; // R4
    next_irq = |({next_locked, next_stable} & next_imr); // R26
  end

  // start-up down-counter on every 8th slow clock tick, lock down-counter on slow clock ticks
  logic [5:0] nmul;
  logic       next_oscen;
  always_comb begin
    nmul = next_cgmr[pwrmgr_pkg::FACTOR_LSB +: 6];
    next_oscen = next_cgmr[pwrmgr_pkg::OSCEN_BIT];
    next_slow_div = tick(slow_div, pwrmgr_pkg::SLOW_CYC) ? 16'h0000
                                                         : slow_div + 16'h0001;
    next_osc_div = tick(osc_div, pwrmgr_pkg::OSC_CYC) ? 16'h0000
                                                      : osc_div + 16'h0001;
    next_osc_cnt = osc_cnt;
    next_osc_run = osc_run;
    next_stable  = stable;
    next_pll_cnt = pll_cnt;
    next_pll_run = pll_run;
    next_locked  = locked;
    if (osc_run && tick(osc_div, pwrmgr_pkg::OSC_CYC)) begin
      next_osc_cnt = osc_cnt - 8'h01;
      if (osc_cnt == 8'h01) begin
        next_osc_run = 1'b0;
        next_stable = 1'b1; // R19
      end
    end
    if (osc_set && next_cgmr[pwrmgr_pkg::OSCNT_LSB +: 8] != 8'h00) begin
      next_osc_cnt = next_cgmr[pwrmgr_pkg::OSCNT_LSB +: 8]; // R8
      next_osc_run = 1'b1;
      next_stable = 1'b0;
      next_osc_div = 16'h0000;
    end
    if (!next_oscen) begin
      next_osc_run = 1'b0;
      next_stable = 1'b0; // R19
    end
    if (pll_run && tick(slow_div, pwrmgr_pkg::SLOW_CYC)) begin
      next_pll_cnt = pll_cnt - 8'h01;
      if (pll_cnt == 8'h01) begin
        next_pll_run = 1'b0;
        next_locked = 1'b1; // R20
      end
    end
    if (factor_wr && nmul != 6'h00 &&
        next_cgmr[pwrmgr_pkg::PLLCNT_LSB +: 6] != 6'h00) begin
      next_pll_cnt = {2'b00, next_cgmr[pwrmgr_pkg::PLLCNT_LSB +: 6]}; // R9
      next_pll_run = 1'b1;
      next_locked = 1'b0;
      next_slow_div = 16'h0000;
    end
    if (nmul == 6'h00 || !next_oscen && !next_cgmr[pwrmgr_pkg::BYP_BIT] ||
        !next_stable && !next_cgmr[pwrmgr_pkg::BYP_BIT]) begin
      next_locked = 1'b0; // R20
      if (nmul == 6'h00) next_pll_run = 1'b0; // R6
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      bvalid <= 1'b0;
      bresp <= 2'b00;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'b00;
      aw_rdy <= 1'b1;
      w_rdy <= 1'b1;
      ar_rdy <= 1'b1;
      pcsr <= 32'h0000_0000; // R1
      cgmr <= pwrmgr_pkg::CGMR_RESET;
      pmr <= pwrmgr_pkg::PMR_RESET; // R25
      imr <= 2'b00; // R23
      pin_st <= pwrmgr_pkg::PWRMGR_WAKE; // R25
      pin_o <= 1'b0;
      pin_oe_n <= 1'b1;
      ckoe_n <= 1'b0;
      irq_q <= 1'b0;
      osc_cnt <= 8'h00;
      pll_cnt <= 8'h00;
      osc_run <= 1'b0;
      pll_run <= 1'b0;
      stable <= 1'b0;
      locked <= 1'b0;
      slow_div <= 16'h0000;
      osc_div <= 16'h0000;
    end else begin
      aw_full <= next_aw_full;
      w_full <= next_w_full;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      aw_rdy <= ~next_aw_full;
      w_rdy <= ~next_w_full;
      ar_rdy <= ~next_rvalid;
      pcsr <= next_pcsr;
      cgmr <= next_cgmr;
      pmr <= next_pmr;
      imr <= next_imr;
      pin_st <= next_pin_st;
      pin_o <= next_pin_o;
      pin_oe_n <= next_pin_oe_n;
      ckoe_n <= next_ckoe_n;
      irq_q <= next_irq;
      osc_cnt <= next_osc_cnt;
      pll_cnt <= next_pll_cnt;
      osc_run <= next_osc_run;
      pll_run <= next_pll_run;
      stable <= next_stable;
      locked <= next_locked;
      slow_div <= next_slow_div;
      osc_div <= next_osc_div;
    end
  end

  assign s_axi_awready = aw_rdy;
  assign s_axi_wready  = w_rdy;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_arready = ar_rdy;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;
  assign power_off_pin_o    = pin_o;
  assign power_off_pin_oe_n = pin_oe_n;
  assign clk_out_pin_oe_n   = ckoe_n;
  assign osc_bypass   = cgmr[pwrmgr_pkg::BYP_BIT]; // R2 R3
  assign osc_enable   = cgmr[pwrmgr_pkg::OSCEN_BIT];
  assign source_sel   = cgmr[pwrmgr_pkg::SOURCE_LSB +: 2]; // R7
  assign prescale_sel = cgmr[pwrmgr_pkg::PRESCALE_LSB +: 3]; // R5
  assign pll_factor   = cgmr[pwrmgr_pkg::FACTOR_LSB +: 6]; // R6
  assign pll_on       = locked; // R6 R10
  assign periph_clk_on = pcsr; // R1
  assign irq = irq_q;

  a_irq_follows: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == |({locked, stable} & imr)) // R26
    else $error("irq does not follow flags and mask");
  a_ier_sets: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && aw_addr == pwrmgr_pkg::ADDR_IER && s_axi_wstrb == 4'hf
    |=> (imr & $past(w_data[1:0])) == $past(w_data[1:0])) // R21
    else $error("enable write did not set mask");
  a_idr_clears: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && aw_addr == pwrmgr_pkg::ADDR_IDR && s_axi_wstrb == 4'hf
    |=> (imr & $past(w_data[1:0])) == 2'b00) // R22
    else $error("disable write did not clear mask");
  a_ack_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_go && aw_addr == pwrmgr_pkg::ADDR_PCR && s_axi_wstrb == 4'hf &&
    w_data[pwrmgr_pkg::ACK_BIT] && !wake_edge && !alarm_ev
    |=> pin_st == pwrmgr_pkg::PWRMGR_WAKE) // R12 R13
    else $error("wake ack lost");
  a_stable_off: assert property (@(posedge aclk) disable iff (!aresetn)
    !cgmr[pwrmgr_pkg::OSCEN_BIT] |-> !stable) // R19
    else $error("stable while oscillator off");
  a_lock_nomul: assert property (@(posedge aclk) disable iff (!aresetn)
    cgmr[pwrmgr_pkg::FACTOR_LSB +: 6] == 6'h00 |-> !locked) // R20
    else $error("locked with pll off");
  a_pcsr_impl: assert property (@(posedge aclk) disable iff (!aresetn)
    (pcsr & ~pwrmgr_pkg::PCSR_IMPL) == 32'h0000_0000) // R1
    else $error("unimplemented clock bit set");
  a_ckout_oe: assert property (@(posedge aclk) disable iff (!aresetn)
    clk_out_pin_oe_n == cgmr[pwrmgr_pkg::CKODS_BIT]) // R4
    else $error("clock output enable wrong");
  c_lock: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(locked));
  c_stable: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(stable));
  c_off: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(pin_st));
endmodule : pwrmgr_top

// File: sim/pwrmgr_supply_model.sv
// external supply shut-down input and wake-up push-button
`timescale 1ns/1ps
module pwrmgr_supply_model #(
  parameter logic PULL_LEVEL = 1'b1
) (
  input  wire logic power_off_pin_o,
  input  wire logic power_off_pin_oe_n,
  input  wire logic button,
  output logic      wake_input_pin,
  output logic      shutdown_level
);
  // pin has no pull of its own: the supply's resistor wins when released
  assign shutdown_level = power_off_pin_oe_n ? PULL_LEVEL
                                             : power_off_pin_o;
  assign wake_input_pin = button;
endmodule : pwrmgr_supply_model

// File: sim/test_power_clock_manager.sv
// self-checking bench for the power clock manager
`timescale 1ns/1ps
module test_power_clock_manager;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready, wake_input_pin;
  logic        rtc_alarm, power_off_pin_o, power_off_pin_oe_n, button, lvl;
  logic        clk_out_pin_oe_n, osc_bypass, osc_enable, pll_on, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp, source_sel, rsp;
  logic [2:0]  prescale_sel;
  logic [3:0]  s_axi_wstrb;
  logic [5:0]  pll_factor;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, periph_clk_on, rd;
  int          failures, checks_done, cycles;

  pwrmgr_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .wake_input_pin, .rtc_alarm, .power_off_pin_o, .power_off_pin_oe_n,
    .clk_out_pin_oe_n, .osc_bypass, .osc_enable, .source_sel, .prescale_sel,
    .pll_factor, .pll_on, .periph_clk_on, .irq);
  pwrmgr_supply_model supply (.power_off_pin_o, .power_off_pin_oe_n,
    .button, .wake_input_pin, .shutdown_level(lvl));

  always #5 aclk = ~aclk;

  task automatic end_sim();
    if (failures == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 99000) begin
      failures = failures + 1;
      end_sim();
    end
  end

  task automatic check(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : check

  task automatic ticks(input int n);
    repeat (n) @(posedge aclk);
  endtask : ticks

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t, aw_left, w_left;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_left = 1'b1;
    w_left = 1'b1;
    while (aw_left || w_left) begin
      @(negedge aclk);
      aw_t = aw_left && s_axi_awready === 1'b1;
      w_t = w_left && s_axi_wready === 1'b1;
      @(posedge aclk);
      if (aw_t) s_axi_awvalid <= 1'b0;
      if (w_t) s_axi_wvalid <= 1'b0;
      aw_left = aw_left && !aw_t;
      w_left = w_left && !w_t;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd_chk(input string n, input logic [7:0] a,
                        input logic [31:0] e,
                        input logic [1:0] r = pwrmgr_pkg::RESP_OK);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    check(n, rd, e);
    check({n, "_resp"}, rsp, r);
  endtask : rd_chk

  // pin code: 0 released, 1 driven low, 2 driven high
  task automatic pin_chk(input logic [1:0] sel);
    check("pin_oe_n", power_off_pin_oe_n, sel == 2'h0);
    if (sel == 2'h0) check("supply_in", lvl, 1'b1);
    else check("pin_o", power_off_pin_o, sel == 2'h2);
  endtask : pin_chk

  task automatic cmd(input logic [31:0] d, input logic [1:0] sel);
    wr(pwrmgr_pkg::ADDR_PCR, d);
    ticks(2);
    pin_chk(sel);
  endtask : cmd

  task automatic t_reset();
    rd_chk("pcsr", pwrmgr_pkg::ADDR_PCSR, 32'h0000_0000);
    rd_chk("cgmr", pwrmgr_pkg::ADDR_CGMR, pwrmgr_pkg::CGMR_RESET);
    rd_chk("pmr", pwrmgr_pkg::ADDR_PMR, 32'h0000_0001);
    rd_chk("imr", pwrmgr_pkg::ADDR_IMR, 32'h0000_0000);
    rd_chk("hole", 8'h0c, 32'h0000_0000, pwrmgr_pkg::RESP_ERR);
    rd_chk("wo", pwrmgr_pkg::ADDR_PCR, 32'h0000_0000, pwrmgr_pkg::RESP_ERR);
    pin_chk(2'h0);
    wr(8'h0c, 32'h0000_0001);
    check("wr_hole", rsp, pwrmgr_pkg::RESP_ERR);
  endtask : t_reset

  task automatic t_periph();
    wr(pwrmgr_pkg::ADDR_PCER, 32'hffff_ffff);
    check("clk_on", periph_clk_on, pwrmgr_pkg::PCSR_IMPL);
    rd_chk("pcsr_all", pwrmgr_pkg::ADDR_PCSR, pwrmgr_pkg::PCSR_IMPL);
    wr(pwrmgr_pkg::ADDR_PCDR, 32'h0000_0ffc);
    rd_chk("pcsr_part", pwrmgr_pkg::ADDR_PCSR,
           pwrmgr_pkg::PCSR_IMPL & 32'hffff_f000);
  endtask : t_periph

  task automatic t_cgmr();
    logic [31:0] d;
    for (int i = 0; i < 7; i++) begin
      d = {16'h0000, 2'(i % 3), 6'(i + 1), 1'b1, 3'(i), 1'b1, 1'(i), 1'b0,
           1'(i >> 1)};
      wr(pwrmgr_pkg::ADDR_CGMR, d);
      rd_chk("cgmr", pwrmgr_pkg::ADDR_CGMR, d & pwrmgr_pkg::CGMR_MASK);
      check("bypass", osc_bypass, d[0]);
      check("ck_out", clk_out_pin_oe_n, d[2]);
      check("presc", prescale_sel, d[6:4]);
      check("factor", pll_factor, d[13:8]);
      check("source", source_sel, d[15:14]);
    end
    wr(pwrmgr_pkg::ADDR_CGMR, 32'h0000_0000);
  endtask : t_cgmr

  task automatic t_pin();
    logic [1:0] w;
    for (int s = 0; s < 3; s++) begin
      w = 2'((s + 1) % 3);
      wr(pwrmgr_pkg::ADDR_PMR, 32'(w * 4 + s));
      rd_chk("pmr", pwrmgr_pkg::ADDR_PMR, 32'(w * 4 + s));
      cmd(32'h0000_0001, 2'(s));
      cmd(32'h0000_0000, 2'(s));
      cmd(32'h0000_0002, w);
      cmd(32'h0000_0001, 2'(s));
      cmd(32'h0000_0003, w);
    end
  endtask : t_pin

  task automatic t_wake();
    logic hit;
    for (int e = 0; e < 4; e++) begin
      wr(pwrmgr_pkg::ADDR_PMR, 32'(e * 64 + 9));
      for (int k = 0; k < 2; k++) begin
        cmd(32'h0000_0001, pwrmgr_pkg::LVL_LOW);
        @(posedge aclk);
        button <= ~button;
        ticks(6);
        hit = button ? e[0] : e[1];
        pin_chk(hit ? pwrmgr_pkg::LVL_HIGH : pwrmgr_pkg::LVL_LOW);
      end
    end
  endtask : t_wake

  task automatic t_alarm();
    logic [7:0] pm [5] = '{8'h19, 8'h29, 8'h39, 8'h09, 8'h09};
    logic [1:0] pc [5] = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h1};
    logic [1:0] ex [5] = '{2'h2, 2'h1, 2'h2, 2'h2, 2'h1};
    for (int i = 0; i < 5; i++) begin
      wr(pwrmgr_pkg::ADDR_PMR, {24'h00_0000, pm[i]});
      cmd({30'h0, pc[i]}, pc[i]);
      @(posedge aclk);
      rtc_alarm <= 1'b1;
      ticks(6);
      pin_chk(ex[i]);
      rtc_alarm <= 1'b0;
      ticks(4);
    end
  endtask : t_alarm

  task automatic t_osc();
    int n;
    wr(pwrmgr_pkg::ADDR_IER, 32'h0000_0003);
    rd_chk("imr_both", pwrmgr_pkg::ADDR_IMR, 32'h0000_0003);
    rd_chk("sr_off", pwrmgr_pkg::ADDR_SR, 32'h0000_0000);
    check("irq_off", irq, 1'b0);
    wr(pwrmgr_pkg::ADDR_CGMR, 32'h0001_0002);
    check("osc_en", osc_enable, 1'b1);
    rd_chk("sr_count", pwrmgr_pkg::ADDR_SR, 32'h0000_0000);
    for (n = 0; n < 60000 && irq !== 1'b1; n++) @(posedge aclk);
    check("irq_osc", irq, 1'b1);
    rd_chk("sr_osc", pwrmgr_pkg::ADDR_SR, 32'h0000_0001);
    wr(pwrmgr_pkg::ADDR_IDR, 32'h0000_0001);
    rd_chk("imr_lock", pwrmgr_pkg::ADDR_IMR, 32'h0000_0002);
    check("irq_mask", irq, 1'b0);
    wr(pwrmgr_pkg::ADDR_CGMR, 32'h0201_0302);
    rd_chk("sr_wait", pwrmgr_pkg::ADDR_SR, 32'h0000_0001);
    for (n = 0; n < 20000 && pll_on !== 1'b1; n++) @(posedge aclk);
    check("pll_on", pll_on, 1'b1);
    rd_chk("sr_lock", pwrmgr_pkg::ADDR_SR, 32'h0000_0003);
    check("irq_lock", irq, 1'b1);
    wr(pwrmgr_pkg::ADDR_CGMR, 32'h0201_0002);
    ticks(2);
    check("pll_off", pll_on, 1'b0);
    wr(pwrmgr_pkg::ADDR_IDR, 32'h0000_0002);
    rd_chk("imr_none", pwrmgr_pkg::ADDR_IMR, 32'h0000_0000);
  endtask : t_osc

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, rtc_alarm, button} = 4'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    failures = 0;
    checks_done = 0;
    cycles = 0;
    ticks(20);
    aresetn <= 1'b1;
    t_reset();
    t_periph();
    t_cgmr();
    t_pin();
    t_wake();
    t_alarm();
    t_osc();
    end_sim();
  end
endmodule : test_power_clock_manager
